// ### logic/ssrg_pkg.sv
// shared constants and types for the supply supervisor reset guard
package ssrg_pkg;

	localparam int CLK_PERIOD_NS = 8;
	localparam int NS_PER_US = 1000;
	localparam int NS_PER_MS = 1000000;

	// reset hold interval after the trip level is regained or a manual edge
	localparam int HOLD_MS = 200;
	localparam int HOLD_MIN_MS = 130;
	localparam int HOLD_MAX_MS = 270;
	localparam int HOLD_CYC = (HOLD_MS * NS_PER_MS) / CLK_PERIOD_NS;
	localparam int HOLD_MIN_CYC = (HOLD_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_MAX_CYC = (HOLD_MAX_MS * NS_PER_MS) / CLK_PERIOD_NS;

	// supply_fall_assert_delay: longest time from crossing to reset drive
	localparam int FALL_ASSERT_US = 5;
	localparam int FALL_ASSERT_CYC = (FALL_ASSERT_US * NS_PER_US) / CLK_PERIOD_NS;

	// supply_dip_reject_width: dips this short never assert reset
	localparam int DIP_REJECT_NS = 30;
	localparam int DIP_REJECT_CYC = (DIP_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SUPPLY_FILT_CYC = DIP_REJECT_CYC + 1;

	// manual_reset_trigger glitch immunity
	localparam int MR_GLITCH_NS = 100;
	localparam int MR_GLITCH_CYC = (MR_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MR_FILT_CYC = MR_GLITCH_CYC + 1;

	// nv_program_time: longest internal program cycle
	localparam int PROG_MS = 5;
	localparam int PROG_CYC = (PROG_MS * NS_PER_MS) / CLK_PERIOD_NS;

	// synchroniser stages ahead of each filter
	localparam int SYNC_STAGES = 2;

	// reset values
	localparam logic SUPPLY_LOW_RST = 1'b1;
	localparam logic PIN_LEVEL_RST = 1'b0;

	typedef enum logic [1:0]
	{
		ST_SUPPLY_LOW = 2'b00,
		ST_HOLD = 2'b01,
		ST_RELEASED = 2'b10
	} ssrg_state_t;

	typedef enum logic [1:0]
	{
		CAUSE_NONE = 2'b00,
		CAUSE_SUPPLY = 2'b01,
		CAUSE_MANUAL = 2'b10
	} ssrg_cause_t;

endpackage

// ### logic/ssrg_sync_filter.sv
// two-flop synchroniser followed by a stable-level filter and fall detect
`timescale 1ns/1ps
module ssrg_sync_filter
#(
	parameter int STABLE_CYC = 5,
	parameter logic INIT = 1'b0
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic raw,
	output logic level,
	output logic fell
);

	localparam int CW = $clog2(STABLE_CYC + 1);

	generate
		if (STABLE_CYC < 1)
		begin : g_bad
			$error("ssrg_sync_filter: STABLE_CYC must be at least 1");
		end
	endgenerate

	logic sync_a;
	logic sync_b;
	logic [CW-1:0] run_cnt;
	logic next_sync_a;
	logic next_sync_b;
	logic [CW-1:0] next_run_cnt;
	logic next_level;
	logic next_fell;

	always_comb
	begin
		next_sync_a = raw;
		next_sync_b = sync_a;
		next_run_cnt = '0;
		next_level = level;
		next_fell = 1'b0;
		// level only flips after STABLE_CYC equal samples in a row
		if (sync_b != level)
		begin
			if (run_cnt == CW'(STABLE_CYC - 1))
			begin
				next_level = sync_b;
				next_fell = level & ~sync_b;
			end
			else
			begin
				next_run_cnt = run_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync_a <= INIT;
			sync_b <= INIT;
			run_cnt <= '0;
			level <= INIT;
			fell <= 1'b0;
		end
		else if (clk_en)
		begin
			sync_a <= next_sync_a;
			sync_b <= next_sync_b;
			run_cnt <= next_run_cnt;
			level <= next_level;
			fell <= next_fell;
		end
	end

endmodule // ssrg_sync_filter

// ### logic/ssrg_interval_timer.sv
// restartable one-shot interval counter
`timescale 1ns/1ps
module ssrg_interval_timer
#(
	parameter int CYCLES = 16
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic start,
	output logic busy,
	output logic done
);

	localparam int CW = $clog2(CYCLES + 1);

	generate
		if (CYCLES < 2)
		begin : g_bad
			$error("ssrg_interval_timer: CYCLES must be at least 2");
		end
	endgenerate

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic next_busy;
	logic next_done;

	always_comb
	begin
		next_cnt = cnt;
		next_busy = busy;
		next_done = 1'b0;
		// a start while running begins the interval again from zero
		if (start)
		begin
			next_cnt = '0;
			next_busy = 1'b1;
		end
		else if (busy)
		begin
			if (cnt == CW'(CYCLES - 1))
			begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
			else
			begin
				next_cnt = cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else if (clk_en)
		begin
			cnt <= next_cnt;
			busy <= next_busy;
			done <= next_done;
		end
	end

endmodule // ssrg_interval_timer

// ### logic/ssrg_supervisor.sv
// supply supervisor: open-drain reset hold, manual reset, memory guard
//
// How it works
// - reset driven while supply low, then for the hold interval after recovery
// - hold interval over: stop driving pin, pull resistor returns it high
// - supply falling below trip level asserts reset within 5 us
// - supply dips of 30 ns or less never assert reset
// - falling edge on the reset pin is a manual trigger, edge not level
// - manual trigger keeps reset active the full hold interval
// - manual low pulses under 100 ns are filtered and ignored
// - memory disabled for every operation while reset is active
// - reset aborts a transfer in progress and refuses new ones until release
// - no new program cycle during reset; a running one completes
// - program cycle at most 5 ms, bus and address acknowledge disabled throughout
`timescale 1ns/1ps
module ssrg_supervisor
#(
	parameter int HOLD_CYC = ssrg_pkg::HOLD_CYC,
	parameter int PROG_CYC = ssrg_pkg::PROG_CYC
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic supply_trip_low,
	input wire logic rst_pin_in,
	output logic rst_pin_out,
	output logic rst_pin_oe,
	input wire logic xfer_active,
	input wire logic write_stop,
	output logic reset_active,
	output logic mem_enable,
	output logic bus_enable,
	output logic addr_ack_enable,
	output logic xfer_abort,
	output logic nv_program_start,
	output logic nv_program_busy,
	output logic [1:0] reset_cause
);

	generate
		if (HOLD_CYC < 2 || HOLD_CYC > ssrg_pkg::HOLD_MAX_CYC)
		begin : g_bad_hold
			$error("ssrg_supervisor: HOLD_CYC out of range");
		end
		if (PROG_CYC < 2 || PROG_CYC > ssrg_pkg::PROG_CYC)
		begin : g_bad_prog
			$error("ssrg_supervisor: PROG_CYC out of range");
		end
		// sync, filter and state register must fit inside the fall delay
		if (ssrg_pkg::SYNC_STAGES + ssrg_pkg::SUPPLY_FILT_CYC + 2 > ssrg_pkg::FALL_ASSERT_CYC)
		begin : g_bad_fall
			$error("ssrg_supervisor: supply filter too slow for fall delay");
		end
	endgenerate

	logic supply_below;
	logic pin_level;
	logic pin_fell;
	logic hold_busy;
	logic hold_done;
	logic prog_busy;
	logic prog_done;
	logic hold_start;
	logic manual_trig;
	logic prog_req;

	ssrg_pkg::ssrg_state_t state;
	ssrg_pkg::ssrg_state_t next_state;
	ssrg_pkg::ssrg_cause_t cause;
	ssrg_pkg::ssrg_cause_t next_cause;
	logic next_pin_oe;
	logic next_xfer_abort;
	logic next_prog_start;

	ssrg_sync_filter #(
		.STABLE_CYC(ssrg_pkg::SUPPLY_FILT_CYC),
		.INIT(ssrg_pkg::SUPPLY_LOW_RST)
	) u_supply_filt (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.raw(supply_trip_low),
		.level(supply_below),
		.fell()
	);

	ssrg_sync_filter #(
		.STABLE_CYC(ssrg_pkg::MR_FILT_CYC),
		.INIT(ssrg_pkg::PIN_LEVEL_RST)
	) u_pin_filt (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.raw(rst_pin_in),
		.level(pin_level),
		.fell(pin_fell)
	);

	ssrg_interval_timer #(
		.CYCLES(HOLD_CYC)
	) u_hold_timer (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.start(hold_start),
		.busy(hold_busy),
		.done(hold_done)
	);

	ssrg_interval_timer #(
		.CYCLES(PROG_CYC)
	) u_prog_timer (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.start(prog_req),
		.busy(prog_busy),
		.done(prog_done)
	);

	// only an edge seen while the pin is released counts; our own drive
	// keeps the filtered level low, so it can never produce a fresh fall
	assign manual_trig = pin_fell & ~rst_pin_oe & pin_level == 1'b0 & state == ssrg_pkg::ST_RELEASED;

	// timer restarts every cycle the supply is low, so counting begins at recovery
	assign hold_start = (state == ssrg_pkg::ST_SUPPLY_LOW) | manual_trig;

	// a write stop only programs when out of reset and not already programming
	assign prog_req = write_stop & (state == ssrg_pkg::ST_RELEASED) & ~prog_busy;

	always_comb
	begin
		next_state = state;
		next_cause = cause;
		unique case (state)
			ssrg_pkg::ST_SUPPLY_LOW:
			begin
				if (!supply_below)
				begin
					next_state = ssrg_pkg::ST_HOLD;
				end
			end
			ssrg_pkg::ST_HOLD:
			begin
				if (supply_below)
				begin
					next_state = ssrg_pkg::ST_SUPPLY_LOW;
					next_cause = ssrg_pkg::CAUSE_SUPPLY;
				end
				else if (hold_done)
				begin
					next_state = ssrg_pkg::ST_RELEASED;
				end
			end
			ssrg_pkg::ST_RELEASED:
			begin
				if (supply_below)
				begin
					next_state = ssrg_pkg::ST_SUPPLY_LOW;
					next_cause = ssrg_pkg::CAUSE_SUPPLY;
				end
				else if (manual_trig)
				begin
					next_state = ssrg_pkg::ST_HOLD;
					next_cause = ssrg_pkg::CAUSE_MANUAL;
				end
			end
			default:
			begin
				next_state = ssrg_pkg::ST_SUPPLY_LOW;
			end
		endcase
	end

	always_comb
	begin
		// drive low in every state but released; release hands the pin to the pull-up
		next_pin_oe = (next_state != ssrg_pkg::ST_RELEASED);
		// one pulse when reset arrives over a live transfer
		next_xfer_abort = xfer_active & (state == ssrg_pkg::ST_RELEASED) &
			(next_state != ssrg_pkg::ST_RELEASED);
		next_prog_start = prog_req;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ssrg_pkg::ST_SUPPLY_LOW;
			cause <= ssrg_pkg::CAUSE_SUPPLY;
			rst_pin_oe <= 1'b1;
			xfer_abort <= 1'b0;
			nv_program_start <= 1'b0;
		end
		else if (clk_en)
		begin
			state <= next_state;
			cause <= next_cause;
			rst_pin_oe <= next_pin_oe;
			xfer_abort <= next_xfer_abort;
			nv_program_start <= next_prog_start;
		end
	end

	// open drain: the output value is always low, only the enable moves
	assign rst_pin_out = 1'b0;
	assign reset_active = rst_pin_oe;
	assign mem_enable = ~rst_pin_oe;
	// program cycle is never cut by reset; prog timer ignores state once started
	assign nv_program_busy = prog_busy;
	assign bus_enable = ~rst_pin_oe & ~prog_busy;
	assign addr_ack_enable = ~rst_pin_oe & ~prog_busy;
	assign reset_cause = cause;

endmodule // ssrg_supervisor

// ### dv/ssrg_checker.sv
// port assertions for the supply supervisor
`timescale 1ns/1ps
module ssrg_checker
#(
	parameter int HOLD_CYC = 50,
	parameter int PROG_CYC = 20
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic supply_trip_low,
	input wire logic rst_pin_in,
	input wire logic rst_pin_out,
	input wire logic rst_pin_oe,
	input wire logic xfer_active,
	input wire logic write_stop,
	input wire logic reset_active,
	input wire logic mem_enable,
	input wire logic bus_enable,
	input wire logic addr_ack_enable,
	input wire logic xfer_abort,
	input wire logic nv_program_start,
	input wire logic nv_program_busy,
	input wire logic [1:0] reset_cause
);
	int hcnt;
	int bcnt;
	int next_hcnt;
	int next_bcnt;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// hold counts only while supply is good, so a dip restarts it
	always_comb
	begin
		next_hcnt = (rst_pin_oe && !supply_trip_low) ? hcnt + int'(clk_en) : 0;
		next_bcnt = nv_program_busy ? bcnt + int'(clk_en) : 0;
	end
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hcnt <= 0;
			bcnt <= 0;
		end
		else
		begin
			hcnt <= next_hcnt;
			bcnt <= next_bcnt;
		end
	end
	mem_gate_a: assert property (
		mem_enable == !rst_pin_oe && reset_active == rst_pin_oe)
		else $error("memory gate wrong");
	bus_gate_a: assert property (
		bus_enable == (!rst_pin_oe && !nv_program_busy) && addr_ack_enable == bus_enable)
		else $error("bus gate wrong");
	supply_trip_a: assert property (supply_trip_low[*8] |=> rst_pin_oe)
		else $error("late reset on supply drop");
	hold_max_a: assert property (rst_pin_oe |-> hcnt <= HOLD_CYC + 12)
		else $error("hold too long");
	hold_min_a: assert property ($fell(rst_pin_oe) |-> hcnt >= HOLD_CYC - 1)
		else $error("hold too short");
	mr_trig_a: assert property ($fell(rst_pin_in) && !rst_pin_oe ##0
		!rst_pin_in[*8] ##1 !rst_pin_in[*8] ##1 !rst_pin_in |=> rst_pin_oe)
		else $error("manual edge missed");
	mr_glitch_a: assert property (!rst_pin_oe && rst_pin_in ##1 !rst_pin_in[*8]
		##1 !rst_pin_in[*5] ##1 rst_pin_in |=> !rst_pin_oe[*8])
		else $error("glitch caused reset");
	prog_len_a: assert property ($fell(nv_program_busy) |-> bcnt == PROG_CYC)
		else $error("program length wrong");
	abort_a: assert property (
		xfer_abort == ($rose(rst_pin_oe) && $past(xfer_active)))
		else $error("abort pulse wrong");
endmodule // ssrg_checker
bind ssrg_supervisor ssrg_checker #(.HOLD_CYC(HOLD_CYC), .PROG_CYC(PROG_CYC)) chk (.*);

// ### dv/ssrg_host_model.sv
// behavioural bus master and push-button on the reset line
`timescale 1ns/1ps
module ssrg_host_model
(
	input wire logic ref_clk,
	output logic xfer_active,
	output logic write_stop,
	output logic pin_low
);
	initial
	begin
		xfer_active = 1'b0;
		write_stop = 1'b0;
		pin_low = 1'b0;
	end
	task automatic write_seq(input int len);
		xfer_active <= 1'b1;
		repeat (len) @(posedge ref_clk);
		xfer_active <= 1'b0;
		write_stop <= 1'b1;
		@(posedge ref_clk);
		write_stop <= 1'b0;
	endtask
	task automatic press(input int len);
		pin_low <= 1'b1;
		repeat (len) @(posedge ref_clk);
		pin_low <= 1'b0;
	endtask
endmodule // ssrg_host_model

// ### dv/supply_supervisor_reset_guard_tb.sv
// self-checking bench for the supply supervisor reset guard
`timescale 1ns/1ps
module supply_supervisor_reset_guard_tb;
	localparam int HOLD = 50;
	localparam int PROG = 20;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic supply_trip_low = 1'b0;
	logic clk_en = 1'b1;
	logic rst_pin_in;
	logic rst_pin_out, rst_pin_oe, xfer_active, write_stop, reset_active;
	logic mem_enable, bus_enable, addr_ack_enable, xfer_abort;
	logic nv_program_start, nv_program_busy, pin_low;
	logic [1:0] reset_cause;
	logic [2:0] notes[$];
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;
	int n;
	int k;
	// pull-up wins unless someone sinks the line
	assign rst_pin_in = (rst_pin_oe ? rst_pin_out : 1'b1) && !pin_low;
	ssrg_supervisor #(.HOLD_CYC(HOLD), .PROG_CYC(PROG)) dut (.ref_clk(ref_clk),
		.rst_n(rst_n), .clk_en(clk_en), .supply_trip_low(supply_trip_low),
		.rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
		.xfer_active(xfer_active), .write_stop(write_stop), .reset_active(reset_active),
		.mem_enable(mem_enable), .bus_enable(bus_enable), .addr_ack_enable(addr_ack_enable),
		.xfer_abort(xfer_abort), .nv_program_start(nv_program_start),
		.nv_program_busy(nv_program_busy), .reset_cause(reset_cause));
	ssrg_host_model host (.ref_clk(ref_clk), .xfer_active(xfer_active),
		.write_stop(write_stop), .pin_low(pin_low));
	initial
	begin
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic span(ref logic s, output int len);
		len = 0;
		while (s && len < 400)
		begin
			@(posedge ref_clk);
			len++;
		end
	endtask
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			conclude();
		end
		if (rst_n && $rose(rst_pin_oe))
			chk("abort_cause", {xfer_abort, reset_cause}, notes.pop_front());
	end
	initial
	begin
		n = $urandom(91426);
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		chk("mem_off", mem_enable, 1'h0);
		span(rst_pin_oe, n);
		chk("pwrup_hold", n >= HOLD && n <= HOLD + 12, 1'h1);
		chk("pin_free", {rst_pin_in, mem_enable, bus_enable}, 3'h7);
		$display("powerup end");
		for (int i = 0; i < 2; i++)
		begin
			supply_trip_low <= 1'b1;
			repeat (i ? $urandom_range(1, 3) : 4) @(posedge ref_clk);
			supply_trip_low <= 1'b0;
			repeat (20) @(posedge ref_clk);
			chk("dip", rst_pin_oe, 1'h0);
		end
		$display("dip end");
		host.write_seq(3);
		@(posedge ref_clk);
		chk("prog_go", {nv_program_start, nv_program_busy, bus_enable}, 3'h6);
		// frozen edges must not count towards the program time
		clk_en <= 1'b0;
		repeat ($urandom_range(2, 6)) @(posedge ref_clk);
		clk_en <= 1'b1;
		chk("freeze_busy", {nv_program_busy, bus_enable}, 2'h2);
		span(nv_program_busy, n);
		chk("prog_len", n, PROG);
		$display("program end");
		for (int i = 0; i < 4; i++)
		begin
			k = 0;
			if (i > 1)
				notes.push_back(3'h2);
			fork
				host.press(i == 0 ? 13 : i == 1 ? $urandom_range(1, 12) : i == 2 ? 100 : 14);
			join_none
			while (!rst_pin_oe && k < 40)
			begin
				@(posedge ref_clk);
				k++;
			end
			chk("mr_delay", k >= 16 && k <= 19, i > 1);
			span(rst_pin_oe, n);
			chk("mr_hold", n >= HOLD - 1 && n <= HOLD + 2, i > 1);
			repeat (60) @(posedge ref_clk);
			chk("mr_level", rst_pin_oe, 1'h0);
		end
		$display("manual end");
		host.write_seq(2);
		notes.push_back(3'h5);
		fork
			host.write_seq(12);
			begin
				supply_trip_low <= 1'b1;
				repeat (10) @(posedge ref_clk);
				supply_trip_low <= 1'b0;
			end
		join
		span(nv_program_busy, n);
		chk("prog_survive", n, PROG - 12);
		span(rst_pin_oe, n);
		chk("notes_left", notes.size(), 0);
		$display("abort end");
		conclude();
	end
endmodule // supply_supervisor_reset_guard_tb
